// file: logic/sbc_config_interrupt_registers.sv
// Upper register bank: device setup, transceiver and switch control,
// pulse channels, cyclic timers, restart counter and interrupt flags.
// Assumes event and mode inputs come from logic on clk; pins are raw.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_regs_cfg.svh"

// Overview of operation
// - Channel A duty: 0x20[1:0] high, 0x21 low
// - Channel B duty: 0x23[1:0] high, 0x24 low
// - Restart entries counted; limit reached requests sleep
// - Power-up restores sleep-wake error timer default
// - Summary register ORs the flag groups
// - Each flag group has its mask register
// - Group D holds transceiver and switch events
// - Setup bit keeps serial port alive asleep while I/O supply is good
// - 0x1D sets transceiver mode and timeout
// - 0x29 configures reset and fail-safe pins
// - Frames are 16 or 24 clocks
// - Sample rising, shift falling, float when deselected
module sbc_config_interrupt_registers
  import sbc_regs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       cs_n_pin,
  input  wire logic       sclk_pin,
  input  wire logic       sdi_pin,
  output logic            sdo_out,
  output logic            sdo_oe,
  input  wire logic       crc_enable,
  input  wire logic       sleep_mode,
  input  wire logic       io_supply_ok,
  input  wire logic       restart_entry,
  input  wire reg_byte_t  irq_event_a,
  input  wire reg_byte_t  irq_event_b,
  input  wire reg_byte_t  irq_event_c,
  input  wire logic [3:0] transceiver_event,
  input  wire logic [3:0] high_side_event,
  output reg_byte_t       device_setup,
  output reg_byte_t       limp_setup,
  output reg_byte_t       sleep_wake_error_timer,
  output logic [1:0]      transceiver_mode,
  output logic            dominant_timeout_enable,
  output reg_byte_t       high_side_control,
  output reg_byte_t       pulse_a_frequency,
  output logic [9:0]      pulse_a_duty,
  output reg_byte_t       pulse_b_frequency,
  output logic [9:0]      pulse_b_duty,
  output reg_byte_t       cyclic_timer_a,
  output reg_byte_t       cyclic_timer_b,
  output reg_byte_t       reset_pin_control,
  output logic            serial_port_enable,
  output logic            sleep_request,
  output logic            irq_pending
);

  // Bus side
  logic      rd_req, wr_req, frame_error;
  reg_addr_t rd_addr, wr_addr;
  reg_byte_t wr_data;
  reg_byte_t rd_data_r;
  reg_byte_t rd_value;

  // Stored registers
  reg_byte_t  device_setup_r;
  reg_byte_t  limp_setup_r;
  reg_byte_t  sleep_wake_error_timer_r;
  reg_byte_t  xcvr_control_r;
  reg_byte_t  high_side_r;
  reg_byte_t  pa_freq_r;
  logic [1:0] pa_duty_hi_r;
  reg_byte_t  pa_duty_lo_r;
  reg_byte_t  pb_freq_r;
  logic [1:0] pb_duty_hi_r;
  reg_byte_t  pb_duty_lo_r;
  reg_byte_t  timer_a_r;
  reg_byte_t  timer_b_r;
  logic [3:0] restart_limit_r;
  logic [3:0] restart_count_r;
  logic [3:0] restart_count_nxt;
  reg_byte_t  reset_pin_r;
  reg_byte_t  flags_a_r, flags_b_r, flags_c_r, flags_d_r;
  reg_byte_t  mask_a_r, mask_b_r, mask_c_r, mask_d_r;
  reg_byte_t  irq_summary;
  reg_byte_t  event_c_all;
  logic       sleep_request_r;
  logic       irq_pending_r;

  // True for every address that holds a register in this bank
  function automatic logic is_mapped(input reg_addr_t a);
    case (a)
      `OFS_DEVICE_SETUP, `OFS_LIMP_SETUP, `OFS_SLEEP_WAKE_ERROR_TIMER, `OFS_XCVR_CONTROL,
      `OFS_HIGH_SIDE, `OFS_PA_FREQ, `OFS_PA_DUTY_HI, `OFS_PA_DUTY_LO,
      `OFS_PB_FREQ, `OFS_PB_DUTY_HI, `OFS_PB_DUTY_LO, `OFS_TIMER_A,
      `OFS_TIMER_B, `OFS_RESTART, `OFS_RESET_PIN, `OFS_IRQ_SUMMARY,
      `OFS_IRQ_FLAGS_A, `OFS_IRQ_FLAGS_B, `OFS_IRQ_FLAGS_C, `OFS_IRQ_MASK_A,
      `OFS_IRQ_MASK_B, `OFS_IRQ_MASK_C, `OFS_IRQ_FLAGS_D, `OFS_IRQ_MASK_D:
        is_mapped = 1'b1;
      default:
        is_mapped = 1'b0;
    endcase
  endfunction

  // Write strobe for one address
  function automatic logic wr_hit(input logic req, input reg_addr_t a, input reg_addr_t target);
    wr_hit = req && (a == target) && is_mapped(a);
  endfunction

  // Serial port stays usable asleep only with setup bit and I/O supply
  assign serial_port_enable = !sleep_mode || (device_setup_r[`POS_SLEEP_SERIAL] && io_supply_ok);

  serial_frame_port #(
    .CNT_W (5)
  ) u_port (
    .clk         (clk),
    .rst_n       (rst_n),
    .cs_n_pin    (cs_n_pin),
    .sclk_pin    (sclk_pin),
    .sdi_pin     (sdi_pin),
    .sdo_out     (sdo_out),
    .sdo_oe      (sdo_oe),
    .crc_enable  (crc_enable),
    .port_enable (serial_port_enable),
    .rd_req      (rd_req),
    .rd_addr     (rd_addr),
    .rd_data     (rd_data_r),
    .wr_req      (wr_req),
    .wr_addr     (wr_addr),
    .wr_data     (wr_data),
    .frame_error (frame_error)
  );

  // Device and limp setup
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      device_setup_r <= `RST_DEVICE_SETUP;
      limp_setup_r   <= 8'h00;
    end else begin
      if (wr_hit(wr_req, wr_addr, `OFS_DEVICE_SETUP)) begin
        device_setup_r <= wr_data;
      end
      if (wr_hit(wr_req, wr_addr, `OFS_LIMP_SETUP)) begin
        limp_setup_r <= wr_data;
      end
    end
  end

  // Power-on reset always returns the timer to its default
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sleep_wake_error_timer_r <= `RST_SLEEP_WAKE_ERROR_TIMER;
    end else if (wr_hit(wr_req, wr_addr, `OFS_SLEEP_WAKE_ERROR_TIMER)) begin
      sleep_wake_error_timer_r <= wr_data;
    end
  end

  // Transceiver mode and dominant timeout
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xcvr_control_r <= 8'h00;
    end else if (wr_hit(wr_req, wr_addr, `OFS_XCVR_CONTROL)) begin
      xcvr_control_r <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      high_side_r <= 8'h00;
    end else if (wr_hit(wr_req, wr_addr, `OFS_HIGH_SIDE)) begin
      high_side_r <= wr_data;
    end
  end

  // Pulse channel A
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pa_freq_r    <= 8'h00;
      pa_duty_hi_r <= 2'b00;
      pa_duty_lo_r <= 8'h00;
    end else begin
      if (wr_hit(wr_req, wr_addr, `OFS_PA_FREQ)) begin
        pa_freq_r <= wr_data;
      end
      if (wr_hit(wr_req, wr_addr, `OFS_PA_DUTY_HI)) begin
        pa_duty_hi_r <= wr_data[1:0];
      end
      if (wr_hit(wr_req, wr_addr, `OFS_PA_DUTY_LO)) begin
        pa_duty_lo_r <= wr_data;
      end
    end
  end

  // Pulse channel B
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pb_freq_r    <= 8'h00;
      pb_duty_hi_r <= 2'b00;
      pb_duty_lo_r <= 8'h00;
    end else begin
      if (wr_hit(wr_req, wr_addr, `OFS_PB_FREQ)) begin
        pb_freq_r <= wr_data;
      end
      if (wr_hit(wr_req, wr_addr, `OFS_PB_DUTY_HI)) begin
        pb_duty_hi_r <= wr_data[1:0];
      end
      if (wr_hit(wr_req, wr_addr, `OFS_PB_DUTY_LO)) begin
        pb_duty_lo_r <= wr_data;
      end
    end
  end

  // Cyclic timers; on-width versus period is the host's concern
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      timer_a_r <= 8'h00;
      timer_b_r <= 8'h00;
    end else begin
      if (wr_hit(wr_req, wr_addr, `OFS_TIMER_A)) begin
        timer_a_r <= wr_data;
      end
      if (wr_hit(wr_req, wr_addr, `OFS_TIMER_B)) begin
        timer_b_r <= wr_data;
      end
    end
  end

  // Reset and fail-safe pin setup
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reset_pin_r <= 8'h00;
    end else if (wr_hit(wr_req, wr_addr, `OFS_RESET_PIN)) begin
      reset_pin_r <= wr_data;
    end
  end

  // Restart counter: a write clears the count, an entry still counts
  always_comb begin
    restart_count_nxt = restart_count_r;
    if (wr_hit(wr_req, wr_addr, `OFS_RESTART)) begin
      restart_count_nxt = 4'h0;
    end
    if (restart_entry && restart_count_nxt != 4'hf) begin
      restart_count_nxt = restart_count_nxt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      restart_limit_r <= `RST_RESTART_LIMIT;
      restart_count_r <= 4'h0;
    end else begin
      restart_count_r <= restart_count_nxt;
      if (wr_hit(wr_req, wr_addr, `OFS_RESTART)) begin
        restart_limit_r <= wr_data[7:4];
      end
    end
  end

  // Limit of zero disables the sleep transition
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sleep_request_r <= 1'b0;
    end else begin
      sleep_request_r <= (restart_limit_r != 4'h0) && (restart_count_r >= restart_limit_r);
    end
  end

  // Interrupt flags: events set, write one clears, set wins
  assign event_c_all = irq_event_c | (8'(frame_error) << `POS_FRAME_ERR);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_a_r <= 8'h00;
      flags_b_r <= `RST_IRQ_FLAGS_B;
      flags_c_r <= 8'h00;
      flags_d_r <= 8'h00;
    end else begin
      flags_a_r <= (flags_a_r & ~(wr_hit(wr_req, wr_addr, `OFS_IRQ_FLAGS_A) ? wr_data : 8'h00)) | irq_event_a;
      flags_b_r <= (flags_b_r & ~(wr_hit(wr_req, wr_addr, `OFS_IRQ_FLAGS_B) ? wr_data : 8'h00)) | irq_event_b;
      flags_c_r <= (flags_c_r & ~(wr_hit(wr_req, wr_addr, `OFS_IRQ_FLAGS_C) ? wr_data : 8'h00)) | event_c_all;
      flags_d_r <= (flags_d_r & ~(wr_hit(wr_req, wr_addr, `OFS_IRQ_FLAGS_D) ? wr_data : 8'h00))
                   | {high_side_event, transceiver_event};
    end
  end

  // Interrupt masks
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_a_r <= `RST_IRQ_MASK_A;
      mask_b_r <= `RST_IRQ_MASK_B;
      mask_c_r <= `RST_IRQ_MASK_C;
      mask_d_r <= `RST_IRQ_MASK_D;
    end else begin
      if (wr_hit(wr_req, wr_addr, `OFS_IRQ_MASK_A)) begin
        mask_a_r <= wr_data;
      end
      if (wr_hit(wr_req, wr_addr, `OFS_IRQ_MASK_B)) begin
        mask_b_r <= wr_data;
      end
      if (wr_hit(wr_req, wr_addr, `OFS_IRQ_MASK_C)) begin
        mask_c_r <= wr_data;
      end
      if (wr_hit(wr_req, wr_addr, `OFS_IRQ_MASK_D)) begin
        mask_d_r <= wr_data;
      end
    end
  end

  // Summary: bit 7 any group, bits 6..3 groups A..D
  assign irq_summary = {(|flags_a_r) | (|flags_b_r) | (|flags_c_r) | (|flags_d_r),
                        |flags_a_r, |flags_b_r, |flags_c_r, |flags_d_r, 3'b000};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_pending_r <= 1'b0;
    end else begin
      irq_pending_r <= |((flags_a_r & mask_a_r) | (flags_b_r & mask_b_r)
                         | (flags_c_r & mask_c_r) | (flags_d_r & mask_d_r));
    end
  end

  // Read multiplexer
  always_comb begin
    rd_value = 8'h00;
    if (is_mapped(rd_addr)) begin
      case (rd_addr)
        `OFS_DEVICE_SETUP: rd_value = device_setup_r;
        `OFS_LIMP_SETUP:   rd_value = limp_setup_r;
        `OFS_SLEEP_WAKE_ERROR_TIMER:    rd_value = sleep_wake_error_timer_r;
        `OFS_XCVR_CONTROL: rd_value = xcvr_control_r;
        `OFS_HIGH_SIDE:    rd_value = high_side_r;
        `OFS_PA_FREQ:      rd_value = pa_freq_r;
        `OFS_PA_DUTY_HI:   rd_value = {6'b000000, pa_duty_hi_r};
        `OFS_PA_DUTY_LO:   rd_value = pa_duty_lo_r;
        `OFS_PB_FREQ:      rd_value = pb_freq_r;
        `OFS_PB_DUTY_HI:   rd_value = {6'b000000, pb_duty_hi_r};
        `OFS_PB_DUTY_LO:   rd_value = pb_duty_lo_r;
        `OFS_TIMER_A:      rd_value = timer_a_r;
        `OFS_TIMER_B:      rd_value = timer_b_r;
        `OFS_RESTART:      rd_value = {restart_limit_r, restart_count_r};
        `OFS_RESET_PIN:    rd_value = reset_pin_r;
        `OFS_IRQ_SUMMARY:  rd_value = irq_summary;
        `OFS_IRQ_FLAGS_A:  rd_value = flags_a_r;
        `OFS_IRQ_FLAGS_B:  rd_value = flags_b_r;
        `OFS_IRQ_FLAGS_C:  rd_value = flags_c_r;
        `OFS_IRQ_FLAGS_D:  rd_value = flags_d_r;
        `OFS_IRQ_MASK_A:   rd_value = mask_a_r;
        `OFS_IRQ_MASK_B:   rd_value = mask_b_r;
        `OFS_IRQ_MASK_C:   rd_value = mask_c_r;
        `OFS_IRQ_MASK_D:   rd_value = mask_d_r;
        default:           rd_value = 8'h00;
      endcase
    end
  end

  // Read data held for the falling-edge shift
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_r <= 8'h00;
    end else if (rd_req) begin
      rd_data_r <= rd_value;
    end
  end

  assign device_setup            = device_setup_r;
  assign limp_setup              = limp_setup_r;
  assign sleep_wake_error_timer  = sleep_wake_error_timer_r;
  assign transceiver_mode        = xcvr_control_r[1:0];
  assign dominant_timeout_enable = ~xcvr_control_r[`POS_DTO_DISABLE];
  assign high_side_control       = high_side_r;
  assign pulse_a_frequency       = pa_freq_r;
  assign pulse_a_duty            = {pa_duty_hi_r, pa_duty_lo_r};
  assign pulse_b_frequency       = pb_freq_r;
  assign pulse_b_duty            = {pb_duty_hi_r, pb_duty_lo_r};
  assign cyclic_timer_a          = timer_a_r;
  assign cyclic_timer_b          = timer_b_r;
  assign reset_pin_control       = reset_pin_r;
  assign sleep_request           = sleep_request_r;
  assign irq_pending             = irq_pending_r;

endmodule // sbc_config_interrupt_registers

`default_nettype wire

// file: logic/sbc_regs_cfg.svh
// Register offsets, reset values and serial frame constants.
// Included by both design modules.
`ifndef SBC_REGS_CFG_SVH
`define SBC_REGS_CFG_SVH

`define OFS_DEVICE_SETUP     7'h1a
`define OFS_LIMP_SETUP       7'h1b
`define OFS_SLEEP_WAKE_ERROR_TIMER        7'h1c
`define OFS_XCVR_CONTROL     7'h1d
`define OFS_HIGH_SIDE        7'h1e
`define OFS_PA_FREQ          7'h1f
`define OFS_PA_DUTY_HI       7'h20
`define OFS_PA_DUTY_LO       7'h21
`define OFS_PB_FREQ          7'h22
`define OFS_PB_DUTY_HI       7'h23
`define OFS_PB_DUTY_LO       7'h24
`define OFS_TIMER_A          7'h25
`define OFS_TIMER_B          7'h26
`define OFS_RESTART          7'h28
`define OFS_RESET_PIN        7'h29
`define OFS_IRQ_SUMMARY      7'h50
`define OFS_IRQ_FLAGS_A      7'h51
`define OFS_IRQ_FLAGS_B      7'h52
`define OFS_IRQ_FLAGS_C      7'h53
`define OFS_IRQ_MASK_A       7'h56
`define OFS_IRQ_MASK_B       7'h57
`define OFS_IRQ_MASK_C       7'h58
`define OFS_IRQ_FLAGS_D      7'h5a
`define OFS_IRQ_MASK_D       7'h5e

`define RST_DEVICE_SETUP     8'h80
`define RST_SLEEP_WAKE_ERROR_TIMER        8'h30
`define RST_RESTART_LIMIT    4'h4
`define RST_IRQ_FLAGS_B      8'h40
`define RST_IRQ_MASK_A       8'hb0
`define RST_IRQ_MASK_B       8'h37
`define RST_IRQ_MASK_C       8'hbc
`define RST_IRQ_MASK_D       8'hcc

`define POS_SLEEP_SERIAL     7
`define POS_DTO_DISABLE      2
`define POS_FRAME_ERR        0

`define FRAME_BITS_PLAIN     5'd16
`define FRAME_BITS_CRC       5'd24
`define ADDR_BITS            5'd8

`endif

// file: logic/sbc_regs_pkg.sv
// Types shared by the serial port and the register bank.
// Constants live in sbc_regs_cfg.svh.
package sbc_regs_pkg;
  typedef enum logic [0:0] {
    LINK_IDLE   = 1'b0,
    LINK_ACTIVE = 1'b1
  } link_state_e;
  typedef logic [6:0] reg_addr_t;
  typedef logic [7:0] reg_byte_t;
endpackage

// file: logic/serial_frame_port.sv
// Serial frame port: synchronises the chip-select, clock and data pins,
// shifts frames MSB first and issues read and write requests.
// Assumes the serial clock is slower than one eighth of clk.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_regs_cfg.svh"

module serial_frame_port
  import sbc_regs_pkg::*;
#(
  parameter int CNT_W = 5
) (
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire logic      cs_n_pin,
  input  wire logic      sclk_pin,
  input  wire logic      sdi_pin,
  output logic           sdo_out,
  output logic           sdo_oe,
  input  wire logic      crc_enable,
  input  wire logic      port_enable,
  output logic           rd_req,
  output reg_addr_t      rd_addr,
  input  wire reg_byte_t rd_data,
  output logic           wr_req,
  output reg_addr_t      wr_addr,
  output reg_byte_t      wr_data,
  output logic           frame_error
);
  if (CNT_W < 5) begin : g_cnt_check
    $error("CNT_W must hold a count of 24");
  end

  logic             cs_meta_r, cs_sync_r, cs_prev_r;
  logic             sclk_meta_r, sclk_sync_r, sclk_prev_r;
  logic             sdi_meta_r, sdi_sync_r;
  link_state_e      state_r;
  logic [CNT_W-1:0] cnt_r;
  logic [23:0]      in_sh_r;
  logic [7:0]       out_sh_r;
  logic             write_bit_r;
  logic             sclk_rise, sclk_fall, cs_fall, cs_rise, len_ok;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {cs_meta_r, cs_sync_r, cs_prev_r} <= 3'b111;
      {sclk_meta_r, sclk_sync_r, sclk_prev_r} <= 3'b000;
      {sdi_meta_r, sdi_sync_r} <= 2'b00;
    end else begin
      {cs_meta_r, cs_sync_r, cs_prev_r} <= {cs_n_pin, cs_meta_r, cs_sync_r};
      {sclk_meta_r, sclk_sync_r, sclk_prev_r} <= {sclk_pin, sclk_meta_r, sclk_sync_r};
      {sdi_meta_r, sdi_sync_r} <= {sdi_pin, sdi_meta_r};
    end
  end

  assign sclk_rise = sclk_sync_r & ~sclk_prev_r;
  assign sclk_fall = ~sclk_sync_r & sclk_prev_r;
  assign cs_fall   = cs_prev_r & ~cs_sync_r;
  assign cs_rise   = ~cs_prev_r & cs_sync_r;
  assign len_ok    = (cnt_r == (crc_enable ? CNT_W'(`FRAME_BITS_CRC) : CNT_W'(`FRAME_BITS_PLAIN)));
  assign sdo_oe    = (state_r == LINK_ACTIVE);

  // Frame state, bit count and input shifting on rising edges
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r     <= LINK_IDLE;
      cnt_r       <= '0;
      in_sh_r     <= '0;
      write_bit_r <= 1'b0;
    end else begin
      case (state_r)
        LINK_IDLE: begin
          if (cs_fall && port_enable) begin
            state_r <= LINK_ACTIVE;
            cnt_r   <= '0;
          end
        end
        LINK_ACTIVE: begin
          if (cs_rise) begin
            state_r <= LINK_IDLE;
          end else if (sclk_rise) begin
            in_sh_r <= {in_sh_r[22:0], sdi_sync_r};
            if (cnt_r != '1) begin
              cnt_r <= cnt_r + 1'b1;
            end
            if (cnt_r == CNT_W'(`ADDR_BITS - 5'd1)) begin
              write_bit_r <= sdi_sync_r;
            end
          end
        end
        default: state_r <= LINK_IDLE;
      endcase
    end
  end

  // Requests toward the register bank
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_req      <= 1'b0;
      rd_addr     <= '0;
      wr_req      <= 1'b0;
      wr_addr     <= '0;
      wr_data     <= '0;
      frame_error <= 1'b0;
    end else begin
      rd_req      <= 1'b0;
      wr_req      <= 1'b0;
      frame_error <= 1'b0;
      if (state_r == LINK_ACTIVE && sclk_rise && !cs_rise && cnt_r == CNT_W'(`ADDR_BITS - 5'd1)) begin
        rd_req  <= 1'b1;
        rd_addr <= in_sh_r[6:0];
      end
      if (state_r == LINK_ACTIVE && cs_rise) begin
        if (!len_ok) begin
          frame_error <= 1'b1;
        end else if (write_bit_r) begin
          wr_req  <= 1'b1;
          wr_addr <= rd_addr;
          wr_data <= crc_enable ? in_sh_r[15:8] : in_sh_r[7:0];
        end
      end
    end
  end

  // Output data changes on falling edges once the address byte is in
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sdo_out  <= 1'b0;
      out_sh_r <= '0;
    end else if (state_r != LINK_ACTIVE) begin
      sdo_out  <= 1'b0;
      out_sh_r <= '0;
    end else if (sclk_fall) begin
      if (cnt_r == CNT_W'(`ADDR_BITS)) begin
        sdo_out  <= rd_data[7];
        out_sh_r <= {rd_data[6:0], 1'b0};
      end else if (cnt_r > CNT_W'(`ADDR_BITS)) begin
        sdo_out  <= out_sh_r[7];
        out_sh_r <= {out_sh_r[6:0], 1'b0};
      end
    end
  end
endmodule // serial_frame_port

`default_nettype wire

// file: test/sbc_cfg_asserts.sv
// Checker on the ports of the register bank.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module sbc_cfg_asserts
  import sbc_regs_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       cs_n_pin,
  input wire logic       sdo_oe,
  input wire logic       sleep_mode,
  input wire logic       io_supply_ok,
  input wire logic       restart_entry,
  input wire reg_byte_t  device_setup,
  input wire reg_byte_t  sleep_wake_error_timer,
  input wire reg_byte_t  reset_pin_control,
  input wire logic [1:0] transceiver_mode,
  input wire logic       dominant_timeout_enable,
  input wire logic [9:0] pulse_a_duty,
  input wire logic [9:0] pulse_b_duty,
  input wire logic       serial_port_enable,
  input wire logic       sleep_request,
  input wire logic       irq_pending
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_reset_defaults: assert property ($rose(rst_n) |-> sleep_wake_error_timer == 8'h30 && !sleep_request && !irq_pending)
    else $error("defaults after reset wrong");
  a_port_enable: assert property (serial_port_enable == (!sleep_mode || (device_setup[7] && io_supply_ok)))
    else $error("serial port enable wrong");
  a_oe_deselect: assert property (cs_n_pin [*5] |-> !sdo_oe)
    else $error("data out driven while deselected");
  a_duty_write: assert property ($changed({pulse_a_duty, pulse_b_duty}) |-> $past(cs_n_pin, 2))
    else $error("duty changed inside a frame");
  a_mode_write: assert property ($changed({transceiver_mode, dominant_timeout_enable}) |-> $past(cs_n_pin, 2))
    else $error("transceiver control changed inside a frame");
  a_pin_write: assert property ($changed(reset_pin_control) |-> $past(cs_n_pin, 2))
    else $error("pin control changed inside a frame");
  a_sleep_cause: assert property ($rose(sleep_request) |-> $past(restart_entry, 2) || $past(restart_entry))
    else $error("sleep request without restart entry");
  a_sleep_clear: assert property ($fell(sleep_request) |-> $past(cs_n_pin, 2))
    else $error("sleep request dropped inside a frame");
  cover property ($rose(sleep_request));
  cover property ($rose(irq_pending));
  cover property ($changed(pulse_a_duty));
endmodule // sbc_cfg_asserts
bind sbc_config_interrupt_registers sbc_cfg_asserts sbc_cfg_asserts_i (.clk, .rst_n, .cs_n_pin, .sdo_oe,
  .sleep_mode, .io_supply_ok, .restart_entry, .device_setup, .sleep_wake_error_timer, .reset_pin_control,
  .transceiver_mode, .dominant_timeout_enable, .pulse_a_duty, .pulse_b_duty, .serial_port_enable,
  .sleep_request, .irq_pending);
`default_nettype wire

// file: test/sbc_config_interrupt_registers_bench.sv
// Bench for the register bank driven through the serial host model.
// Queued notes compared on falling clk edges.
`timescale 1ns/1ps
`default_nettype none
module sbc_config_interrupt_registers_bench
  import sbc_regs_pkg::*;
;
  logic clk, rst_n, crc_enable, sleep_mode, io_supply_ok, restart_entry, dominant_timeout_enable;
  logic cs_n_pin, sclk_pin, sdi_pin, sdo_out, sdo_oe, serial_port_enable, sleep_request, irq_pending;
  logic [1:0] transceiver_mode;
  logic [3:0] transceiver_event, high_side_event;
  logic [9:0] pulse_a_duty, pulse_b_duty, exp_q [$], got_q [$];
  reg_byte_t irq_event_a, irq_event_b, irq_event_c, device_setup, limp_setup, sleep_wake_error_timer, rd, ev;
  reg_byte_t high_side_control, pulse_a_frequency, pulse_b_frequency, cyclic_timer_a, cyclic_timer_b;
  reg_byte_t reset_pin_control, wd [15];
  reg_addr_t ra [24] = '{7'h1a, 7'h1b, 7'h1c, 7'h1d, 7'h1e, 7'h1f, 7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25,
    7'h26, 7'h28, 7'h29, 7'h50, 7'h51, 7'h52, 7'h53, 7'h56, 7'h57, 7'h58, 7'h5a, 7'h5e};
  reg_byte_t rv [24] = '{8'h80, 8'h00, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h40, 8'h00, 8'ha0, 8'h00, 8'h40, 8'h00, 8'hb0, 8'h37, 8'hbc, 8'h00, 8'hcc};
  int mismatches = 0;
  int checked = 0;
  sbc_config_interrupt_registers sbc_config_interrupt_registers_i (.*);
  serial_host_model serial_host_model_i (.clk, .sdo_out, .sdo_oe, .cs_n_pin, .sclk_pin, .sdi_pin);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic note(input logic [9:0] got, input logic [9:0] exp);
    got_q.push_back(got);
    exp_q.push_back(exp);
  endtask
  always @(negedge clk) while (got_q.size() > 0) check(got_q.pop_front(), exp_q.pop_front());
  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    serial_host_model_i.xfer({a, 1'b1, d, 8'h00}, crc_enable ? 24 : 16, rd);
  endtask
  task automatic rdc(input reg_addr_t a, input reg_byte_t e);
    serial_host_model_i.xfer({a, 1'b0, 8'h00, 8'h00}, crc_enable ? 24 : 16, rd);
    note(10'(rd), 10'(e));
  endtask
  function automatic reg_byte_t keep(input int i, input reg_byte_t d);
    return (i == 6 || i == 9) ? (d & 8'h03) : (i == 13) ? {d[7:4], 4'h0} : d;
  endfunction
  task automatic end_sim;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #3000000;
    mismatches++;
    end_sim();
  end
  initial begin
    {rst_n, crc_enable, sleep_mode, io_supply_ok, restart_entry} = 5'b00010;
    {irq_event_a, irq_event_b, irq_event_c, transceiver_event, high_side_event} = '0;
    void'($urandom(11040));
    serial_host_model_i.step(2);
    rst_n = 1'b1;
    serial_host_model_i.step(4);
    for (int i = 0; i < 24; i++) rdc(ra[i], rv[i]);
    rdc(7'h7f, 8'h00);
    $display("reset values done");
    for (int c = 0; c < 2; c++) begin
      crc_enable = c[0];
      for (int i = 0; i < 15; i++) begin
        wd[i] = 8'($urandom);
        if (i == 7 || i == 10) wd[i][1] = 1'b1;
        if (i == 11 || i == 12) wd[i][2:0] = '0;
        wr(ra[i], wd[i]);
      end
      wr(7'h30, 8'($urandom));
      rdc(7'h30, 8'h00);
      for (int i = 0; i < 15; i++) rdc(ra[i], keep(i, wd[i]));
      note(pulse_a_duty, {wd[6][1:0], wd[7]});
      note(pulse_b_duty, {wd[9][1:0], wd[10]});
      note(10'({transceiver_mode, dominant_timeout_enable}), 10'({wd[3][1:0], ~wd[3][2]}));
      note(10'(reset_pin_control), 10'(wd[14]));
      note(10'(high_side_control), 10'(wd[4]));
    end
    crc_enable = 1'b0;
    $display("read write done");
    ev = 8'($urandom);
    {irq_event_a, irq_event_b, irq_event_c, high_side_event, transceiver_event} = {ev, ev, ev, 8'h84};
    serial_host_model_i.step(1);
    {irq_event_a, irq_event_b, irq_event_c, high_side_event, transceiver_event} = '0;
    serial_host_model_i.step(3);
    note(10'(irq_pending), 10'h1);
    rdc(7'h5a, 8'h84);
    rdc(7'h51, ev);
    rdc(7'h50, {1'b1, |ev, 1'b1, |ev, 4'h8});
    wr(7'h56, 8'h00);
    wr(7'h5e, 8'h00);
    wr(7'h52, 8'hff);
    wr(7'h53, 8'hff);
    note(10'(irq_pending), 10'h0);
    wr(7'h5a, 8'hff);
    wr(7'h51, 8'hff);
    rdc(7'h50, 8'h00);
    $display("flags done");
    wr(7'h28, 8'h20);
    for (int k = 1; k < 3; k++) begin
      restart_entry = 1'b1;
      serial_host_model_i.step(1);
      restart_entry = 1'b0;
      serial_host_model_i.step(3);
      note(10'(sleep_request), 10'(k == 2));
    end
    rdc(7'h28, 8'h22);
    wr(7'h28, 8'h20);
    note(10'(sleep_request), 10'h0);
    $display("restart done");
    serial_host_model_i.xfer({7'h1e, 1'b1, ~wd[4], 8'h00}, 15, rd);
    rdc(7'h53, 8'h01);
    rdc(7'h1e, wd[4]);
    wr(7'h1a, 8'h80);
    note(10'(device_setup), 10'h80);
    for (int s = 0; s < 4; s++) begin
      {sleep_mode, io_supply_ok} = s[1:0];
      serial_host_model_i.step(1);
      note(10'(serial_port_enable), 10'(!s[1] || s[0]));
    end
    {sleep_mode, io_supply_ok} = 2'b01;
    $display("sleep port done");
    wr(7'h1c, 8'h55);
    rst_n = 1'b0;
    serial_host_model_i.step(2);
    rst_n = 1'b1;
    serial_host_model_i.step(4);
    rdc(7'h1c, 8'h30);
    note(10'(sleep_wake_error_timer), 10'h30);
    $display("power up default done");
    serial_host_model_i.step(2);
    end_sim();
  end
endmodule // sbc_config_interrupt_registers_bench
`default_nettype wire

// file: test/serial_host_model.sv
// Host side of the serial link: frames MSB first, sclk idle low.
// Released data line reads inverse of last driven bit.
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input  wire logic clk,
  input  wire logic sdo_out,
  input  wire logic sdo_oe,
  output logic      cs_n_pin,
  output logic      sclk_pin,
  output logic      sdi_pin
);
  logic last_r = 1'b0;
  logic line;
  assign line = sdo_oe ? sdo_out : ~last_r;
  always @(posedge clk) if (sdo_oe) last_r <= sdo_out;
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    sdi_pin = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic xfer(input logic [23:0] v, input int n, output logic [7:0] rd);
    cs_n_pin = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi_pin = v[23-i];
      step(5);
      if (i >= 8 && i < 16) rd[15-i] = line;
      sclk_pin = 1'b1;
      step(5);
      sclk_pin = 1'b0;
    end
    step(5);
    cs_n_pin = 1'b1;
    step(8);
  endtask
endmodule // serial_host_model
`default_nettype wire
